// ---- dv/ortr_props.sv ----
`timescale 1ns/1ns
module ortr_props
	import ortr_pkg::*;
(
	// clock and reset
	input wire logic        mclk,
	input wire logic        rst,
	// bus and configuration
	input wire logic        s_axi_awready,
	input wire logic [15:0] factory_trim,
	input wire logic        cfg_guard_bit,
	input wire logic        pll_clock_choice,
	// watched outputs
	input wire logic        pll_settled_clr,
	input wire logic        osc_stable_clr,
	input ortr_trim_t       osc_trim,
	input ortr_freq_split_t freq_split,
	input ortr_tc_comp_t    tc_comp
);
	// single domain, reset masks every check
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	clr_pair_a: assert property (pll_settled_clr == osc_stable_clr)
		else $error("flag clears not paired");
	// the clear pulse follows the handshake edge by exactly one cycle
	clr_cause_a: assert property (pll_settled_clr |->
		$past(s_axi_awready && pll_clock_choice && !cfg_guard_bit))
		else $error("flag clear without accepted write");
	clr_pulse_a: assert property (pll_settled_clr |=> !pll_settled_clr)
		else $error("flag clear longer than one cycle");
	// $past depth 2 skips the factory load edge after reset
	trim_guard_a: assert property ($changed(osc_trim) && !$past(rst, 2) |->
		$past(s_axi_awready && !cfg_guard_bit))
		else $error("trim changed without accepted write");
	trim_load_a: assert property ($fell(rst) |=>
		osc_trim == {$past(factory_trim[15:11]), $past(factory_trim[9:0])})
		else $error("factory value not loaded");
	split_track_a: assert property (freq_split == osc_trim.freq_adjust)
		else $error("freq split differs from trim");
	tc_enable_a: assert property (
		tc_comp.enable == ($past(osc_trim.temp_coeff_adjust[3:0]) != 4'h0))
		else $error("compensation enable wrong");
	tc_dir_a: assert property (tc_comp.enable |->
		tc_comp[4:0] == $past(osc_trim.temp_coeff_adjust))
		else $error("compensation direction or magnitude wrong");
	clr_c: cover property (pll_settled_clr);
	tc_pos_c: cover property (tc_comp.enable && tc_comp.positive);
	tc_neg_c: cover property (tc_comp.enable && !tc_comp.positive);
endmodule : ortr_props

bind ortr_top ortr_props chk (.mclk(mclk), .rst(rst), .s_axi_awready(s_axi_awready),
	.factory_trim(factory_trim), .cfg_guard_bit(cfg_guard_bit), .osc_trim(osc_trim),
	.pll_clock_choice(pll_clock_choice), .pll_settled_clr(pll_settled_clr),
	.osc_stable_clr(osc_stable_clr), .freq_split(freq_split), .tc_comp(tc_comp));

// ---- dv/testbench.sv ----
`timescale 1ns/1ns
module testbench
	import ortr_pkg::*;
;
	logic             mclk = 1'h0, rst = 1'h1;
	logic [11:0]      awaddr = 12'h0, araddr = 12'h0;
	logic [31:0]      wdata = 32'h0;
	logic             awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic             guard = 1'h1, pll = 1'h0, settled = 1'h0, stable = 1'h0;
	logic [15:0]      factory = 16'hA5C3;
	logic [3:0]       strb = 4'h1;
	logic             awready, wready, bvalid, arready, rvalid, pclr, oclr;
	logic [1:0]       bresp, rresp;
	logic [31:0]      rdata;
	ortr_trim_t       trim;
	ortr_freq_split_t split;
	ortr_tc_comp_t    tc;
	int               fails = 0, comparisons = 0, cycles = 0, clr_seen = 0;

	ortr_top uut (.mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.factory_trim(factory), .cfg_guard_bit(guard), .pll_clock_choice(pll),
		.pll_settled_flag(settled), .osc_stable_flag(stable), .pll_settled_clr(pclr),
		.osc_stable_clr(oclr), .osc_trim(trim), .freq_split(split), .tc_comp(tc));

	always #4 mclk = ~mclk;

	// counts clear pulses so a refused write can be told from an accepted one
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (pclr === 1'h1 && oclr === 1'h1) clr_seen <= clr_seen + 1;
		if (cycles == 5000)
		begin
			fails++;
			complete_run();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// both channels offered together, each dropped when its ready is seen
	task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge mclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do
		begin
			@(posedge mclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end
		while (bvalid !== 1'h1);
		check({30'h0, bresp}, {30'h0, er});
		bready <= 1'h0;
		repeat (3) @(posedge mclk);
	endtask : axi_wr

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do
		begin
			@(posedge mclk);
			if (arready) arvalid <= 1'h0;
		end
		while (rvalid !== 1'h1);
		check(rdata, e);
		check({30'h0, rresp}, {30'h0, er});
		rready <= 1'h0;
	endtask : rd_chk

	task automatic t_reset(input logic [15:0] f);
		factory <= f;
		rst <= 1'h1;
		repeat (20) @(posedge mclk);
		rst <= 1'h0;
		repeat (3) @(posedge mclk);
		check({17'h0, trim}, {17'h0, f[15:11], f[9:0]});
		rd_chk(12'h060, {24'h0, f[15:11], 1'h0, f[9:8]}, ORTR_RESP_OKAY);
		rd_chk(12'h064, {24'h0, f[7:0]}, ORTR_RESP_OKAY);
		$display("test reset done");
	endtask : t_reset

	task automatic t_write;
		int n;
		n = clr_seen;
		guard <= 1'h1; // guard set by its own register
		pll <= 1'h1;
		axi_wr(12'h060, 8'hFF, ORTR_RESP_OKAY);
		rd_chk(12'h060, 32'hA1, ORTR_RESP_OKAY);
		check(clr_seen, n);
		guard <= 1'h0; // released as if 0x26 went to the guard register
		axi_wr(12'h060, 8'h47, ORTR_RESP_OKAY);
		check(clr_seen, n + 1);
		rd_chk(12'h060, 32'h43, ORTR_RESP_OKAY);
		// lane 0 strobe low: the write must neither land nor clear flags
		strb <= 4'h0;
		axi_wr(12'h064, 8'h00, ORTR_RESP_OKAY);
		check(clr_seen, n + 1);
		rd_chk(12'h064, 32'hC3, ORTR_RESP_OKAY);
		strb <= 4'h1;
		pll <= 1'h0;
		axi_wr(12'h064, 8'h3C, ORTR_RESP_OKAY);
		check(clr_seen, n + 1);
		check({22'h0, split}, {22'h0, 4'hC, 6'h3C});
		check({17'h0, trim}, {17'h0, 5'h08, 10'h33C});
		$display("test write done");
	endtask : t_write

	// every compensation code, disabled ones judged on enable alone
	task automatic t_tc;
		logic [4:0] c;
		for (int i = 0; i < 32; i++)
		begin
			c = i[4:0];
			axi_wr(12'h060, {c, 3'h3}, ORTR_RESP_OKAY);
			check({31'h0, tc.enable}, {31'h0, c[3:0] != 4'h0});
			if (c[3:0] != 4'h0) check({26'h0, tc}, {26'h0, 1'h1, c});
		end
		$display("test tc done");
	endtask : t_tc

	task automatic t_map;
		settled <= 1'h1;
		pll <= 1'h1;
		axi_wr(12'h100, 8'h00, ORTR_RESP_DECERR);
		rd_chk(12'h100, 32'h0, ORTR_RESP_DECERR);
		rd_chk(12'h080, 32'h16, ORTR_RESP_OKAY);
		$display("test map done");
	endtask : t_map

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run

	initial
	begin
		t_reset(16'hA5C3);
		t_write();
		t_tc();
		t_map();
		t_reset(16'h5A3C);
		complete_run();
	end
endmodule : testbench

// ---- rtl/ortr_pkg.sv ----
package ortr_pkg;

	// register indices as printed, byte address is four times the index
	localparam logic [7:0]  ORTR_IDX_TRIM_UPPER = 8'h18;
	localparam logic [7:0]  ORTR_IDX_TRIM_LOWER = 8'h19;
	localparam logic [7:0]  ORTR_IDX_STATUS     = 8'h20;
	localparam int          ORTR_ADDR_W         = 12;

	// trim word field layout
	localparam int          ORTR_TC_MSB         = 15;
	localparam int          ORTR_TC_LSB         = 11;
	localparam int          ORTR_FREQ_MSB       = 9;
	localparam int          ORTR_FREQ_LSB       = 0;
	localparam int          ORTR_UNDEF_BIT      = 10;
	localparam int          ORTR_COARSE_LSB     = 6;

	// status register bit positions
	localparam int          ORTR_ST_GUARD       = 0;
	localparam int          ORTR_ST_PLL_CHOICE  = 1;
	localparam int          ORTR_ST_PLL_SETTLED = 2;
	localparam int          ORTR_ST_OSC_STABLE  = 3;
	localparam int          ORTR_ST_LOADED      = 4;

	// reset values before the factory load lands
	localparam logic [15:0] ORTR_TRIM_RST       = 16'h0000;

	// bus responses
	localparam logic [1:0]  ORTR_RESP_OKAY      = 2'h0;
	localparam logic [1:0]  ORTR_RESP_DECERR    = 2'h3;

	typedef struct packed {
		logic [4:0] temp_coeff_adjust;
		logic [9:0] freq_adjust;
	} ortr_trim_t;

	typedef struct packed {
		logic       enable;
		logic       positive;
		logic [3:0] magnitude;
	} ortr_tc_comp_t;

	typedef struct packed {
		logic [3:0] coarse;
		logic [5:0] fine;
	} ortr_freq_split_t;

	// reading the trim word, undefined bit forced low
	function automatic logic [15:0] ortr_pack(input ortr_trim_t t);
		ortr_pack = {t.temp_coeff_adjust, 1'b0, t.freq_adjust};
	endfunction : ortr_pack

endpackage : ortr_pkg

// ---- rtl/ortr_tc_decode.sv ----
`timescale 1ns/1ns
module ortr_tc_decode
	import ortr_pkg::*;
(
	// clock and reset
	input  wire logic          mclk,
	input  wire logic          rst,
	// trim field in, compensation control out
	input  wire logic [4:0]    temp_coeff_adjust,
	output ortr_tc_comp_t      tc_comp
);

	// top bit is direction, low four bits the size of the step
	wire logic [3:0] mag_w = temp_coeff_adjust[3:0];
	wire logic       dir_w = temp_coeff_adjust[4];
	// both zero-magnitude codes switch the circuit off, not to zero tc
	wire logic       en_w  = (mag_w != 4'h0);

	ortr_tc_comp_t tc_comp_q;

	// registered so the analog side sees a clean word
	always_ff @(posedge mclk)
	begin
		if (rst)
			tc_comp_q <= '0;
		else
			tc_comp_q <= '{enable: en_w, positive: dir_w, magnitude: mag_w};
	end

	assign tc_comp = tc_comp_q;

endmodule : ortr_tc_decode

// ---- rtl/ortr_top.sv ----
`timescale 1ns/1ns
// Behaviour
// - Upper trim byte sits at index 0x18 and lower at 0x19, forming one 16-bit trim word.
// - On release of system reset the factory trim value is loaded into both bytes.
// - Trim bytes read at any time and take writes only while the guard bit is zero.
// - An accepted trim write while the pll clock choice is one clears pll-settled and stable.
// - Bits 15..11 hold the tc adjust field, driven to the compensation circuit.
// - Bits 9..0 hold freq adjust: upper four coarse steps, lower six fine steps.
// - Tc codes 00000 and 10000 both switch compensation off.
// - Tc top bit picks direction (1 positive) and low four bits the magnitude.
module ortr_top
	import ortr_pkg::*;
(
	// clock and reset
	input  wire logic                   mclk,
	input  wire logic                   rst,
	// axi4-lite write address and data
	input  wire logic [ORTR_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	// axi4-lite read
	input  wire logic [ORTR_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	// factory value from flash
	input  wire logic [15:0]            factory_trim,
	// clock configuration state from neighbouring logic
	input  wire logic                   cfg_guard_bit,
	input  wire logic                   pll_clock_choice,
	input  wire logic                   pll_settled_flag,
	input  wire logic                   osc_stable_flag,
	// flag clear pulses
	output logic                        pll_settled_clr,
	output logic                        osc_stable_clr,
	// oscillator trim outputs
	output ortr_trim_t                  osc_trim,
	output ortr_freq_split_t            freq_split,
	output ortr_tc_comp_t               tc_comp
);

	// byte addresses from the printed indices
	localparam logic [ORTR_ADDR_W-1:0] ADDR_UPPER  = {2'b00, ORTR_IDX_TRIM_UPPER, 2'b00};
	localparam logic [ORTR_ADDR_W-1:0] ADDR_LOWER  = {2'b00, ORTR_IDX_TRIM_LOWER, 2'b00};
	localparam logic [ORTR_ADDR_W-1:0] ADDR_STATUS = {2'b00, ORTR_IDX_STATUS, 2'b00};

	ortr_trim_t        trim_q,    trim_d;
	logic              load_q;
	logic              loaded_q;
	logic              awready_q, wready_q, bvalid_q;
	logic [1:0]        bresp_q;
	logic              arready_q, rvalid_q;
	logic [31:0]       rdata_q;
	logic [1:0]        rresp_q;
	logic              pclr_q,    oclr_q;
	ortr_freq_split_t  split_q;

	// write decode
	wire logic wr_fire    = awready_q & s_axi_awvalid & wready_q & s_axi_wvalid;
	wire logic hit_upper  = (s_axi_awaddr == ADDR_UPPER);
	wire logic hit_lower  = (s_axi_awaddr == ADDR_LOWER);
	wire logic hit_status = (s_axi_awaddr == ADDR_STATUS);
	wire logic wr_mapped  = hit_upper | hit_lower | hit_status;
	// guard only lets through when clear; the guard itself is kept elsewhere
	wire logic wr_open    = ~cfg_guard_bit & s_axi_wstrb[0];
	wire logic wr_upper   = wr_fire & hit_upper & wr_open;
	wire logic wr_lower   = wr_fire & hit_lower & wr_open;
	wire logic wr_trim    = wr_upper | wr_lower;
	wire logic wr_start   = s_axi_awvalid & s_axi_wvalid & ~awready_q & ~bvalid_q;

	// read decode
	wire logic rd_fire    = arready_q & s_axi_arvalid;
	wire logic rd_start   = s_axi_arvalid & ~arready_q & ~rvalid_q;
	wire logic rd_upper   = (s_axi_araddr == ADDR_UPPER);
	wire logic rd_lower   = (s_axi_araddr == ADDR_LOWER);
	wire logic rd_status  = (s_axi_araddr == ADDR_STATUS);
	wire logic rd_mapped  = rd_upper | rd_lower | rd_status;
	wire logic [15:0] trim_word = ortr_pack(trim_q);
	wire logic [7:0]  status_w  = {3'h0, loaded_q, osc_stable_flag, pll_settled_flag,
		pll_clock_choice, cfg_guard_bit};
	wire logic [31:0] rd_value  = rd_upper  ? {24'h0, trim_word[15:8]} :
		rd_lower  ? {24'h0, trim_word[7:0]} :
		rd_status ? {24'h0, status_w} : 32'h0;

	// next trim word: factory load wins over any bus write
	always_comb
	begin
		trim_d = trim_q;
		if (load_q)
			trim_d = '{temp_coeff_adjust: factory_trim[ORTR_TC_MSB:ORTR_TC_LSB],
				freq_adjust: factory_trim[ORTR_FREQ_MSB:ORTR_FREQ_LSB]};
		else if (wr_upper)
		begin
			trim_d.temp_coeff_adjust = s_axi_wdata[7:3];
			trim_d.freq_adjust[9:8]  = s_axi_wdata[1:0];
		end
		else if (wr_lower)
			trim_d.freq_adjust[7:0]  = s_axi_wdata[7:0];
	end

	// trim storage; the load is armed by reset and fires at the first edge after release
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			trim_q   <= ORTR_TRIM_RST[14:0]; // bit 10 has no storage
			load_q   <= 1'b1;
			loaded_q <= 1'b0;
		end
		else
		begin
			trim_q   <= trim_d;
			load_q   <= 1'b0;
			loaded_q <= loaded_q | load_q;
		end
	end

	// flag clears pulse one cycle after an accepted trim write under pll choice
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			pclr_q <= 1'b0;
			oclr_q <= 1'b0;
		end
		else
		begin
			pclr_q <= wr_trim & pll_clock_choice;
			oclr_q <= wr_trim & pll_clock_choice;
		end
	end

	// coarse four bits and fine six bits registered for the oscillator steps
	always_ff @(posedge mclk)
	begin
		if (rst)
			split_q <= '0;
		else
			split_q <= '{coarse: trim_d.freq_adjust[9:ORTR_COARSE_LSB],
				fine: trim_d.freq_adjust[ORTR_COARSE_LSB-1:0]};
	end

	// write channel: waits for address and data together, one write at a time
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= ORTR_RESP_OKAY;
		end
		else
		begin
			awready_q <= wr_start;
			wready_q  <= wr_start;
			if (wr_fire)
			begin
				bvalid_q <= 1'b1;
				bresp_q  <= wr_mapped ? ORTR_RESP_OKAY : ORTR_RESP_DECERR;
			end
			else if (s_axi_bready)
				bvalid_q <= 1'b0;
		end
	end

	// read channel
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0;
			rresp_q   <= ORTR_RESP_OKAY;
		end
		else
		begin
			arready_q <= rd_start;
			if (rd_fire)
			begin
				rvalid_q <= 1'b1;
				rdata_q  <= rd_value;
				rresp_q  <= rd_mapped ? ORTR_RESP_OKAY : ORTR_RESP_DECERR;
			end
			else if (s_axi_rready)
				rvalid_q <= 1'b0;
		end
	end

	// tc compensation control
	ortr_tc_decode u_tc
	(
		.mclk              (mclk),
		.rst               (rst),
		.temp_coeff_adjust (trim_q.temp_coeff_adjust),
		.tc_comp           (tc_comp)
	);

	assign s_axi_awready   = awready_q;
	assign s_axi_wready    = wready_q;
	assign s_axi_bvalid    = bvalid_q;
	assign s_axi_bresp     = bresp_q;
	assign s_axi_arready   = arready_q;
	assign s_axi_rvalid    = rvalid_q;
	assign s_axi_rdata     = rdata_q;
	assign s_axi_rresp     = rresp_q;
	assign pll_settled_clr = pclr_q;
	assign osc_stable_clr  = oclr_q;
	assign osc_trim        = trim_q;
	assign freq_split      = split_q;

endmodule : ortr_top
